// ===== lane_control_word_codec.sv
/*
  Lane control word codec: builds handshake, standby and loss words
  for the transmit symbol stream and recognises them on receive,
  with receive polarity correction and an AHB-Lite register slave.
  Assumes an 8b/10b coder on each side, symbols synchronous to clock,
  and a single slave so hready equals hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none

module lane_control_word_codec (
  input wire logic clock,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic word_req,
  input wire lane_codec_pkg::word_kind_e word_kind,
  output logic word_ack,
  input wire logic standby_req,
  input wire logic no_signal,
  input wire logic rx_error,
  output lane_codec_pkg::symbol_s tx_symbol,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic driver_enable,
  input wire lane_codec_pkg::symbol_s rx_symbol,
  input wire logic rx_valid,
  output lane_codec_pkg::word_kind_e rx_word_kind,
  output logic rx_word_valid,
  output logic [2:0] rx_capability,
  output logic rx_loss_reason,
  output logic rx_flush,
  output logic polarity_swapped
);

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  lane_codec_pkg::control_s control;
  lane_codec_pkg::status_s status;
  logic addr_take;
  logic wr_pending;
  logic [31:0] wr_addr;
  logic polarity_clear;
  logic [3:0] standby_heard;
  logic loss_suppressed;
  logic error_persist;

  // Zero wait states, never an error; hsize is always a word
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_take = hsel && htrans[1] && hready;
  assign polarity_clear = wr_pending &&
    (wr_addr == lane_codec_pkg::CONTROL_OFFSET) && hwdata[3];

  // Address phase capture
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_pending <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else begin
      wr_pending <= addr_take && hwrite;
      wr_addr <= haddr;
    end
  end

  // Read data settled at the address edge, stands through data phase
  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      if (haddr == lane_codec_pkg::CONTROL_OFFSET) begin
        hrdata <= {control[31:4], 1'b0, control[2:0]};
      end else if (haddr == lane_codec_pkg::STATUS_OFFSET) begin
        hrdata <= status;
      end else begin
        hrdata <= 32'h0000_0000; // Unmapped reads as zero
      end
    end
  end

  // Control write; the clear bit is a strobe, never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      control <= lane_codec_pkg::CONTROL_RESET;
    end else if (wr_pending &&
                 (wr_addr == lane_codec_pkg::CONTROL_OFFSET)) begin
      control <= {28'h0000000, 1'b0, hwdata[2:0]};
    end
  end

  always_comb begin
    status = '0;
    status.standby_heard = standby_heard;
    status.far_loss_reason = rx_loss_reason;
    status.far_capability = rx_capability;
    status.error_persist = error_persist;
    status.loss_suppressed = loss_suppressed;
    status.polarity_swapped = polarity_swapped;
  end

  // ----------------------------------------------------------------
  // Word building
  // ----------------------------------------------------------------
  function automatic lane_codec_pkg::symbol_s dsym(input logic [7:0] d);
    dsym = {1'b0, d};
  endfunction

  function automatic lane_codec_pkg::symbol_s ksym(input logic [7:0] d);
    ksym = {1'b1, d};
  endfunction

  // Only normal forms exist here: inverted words cannot be built
  function automatic lane_codec_pkg::word_t build_word(
    input lane_codec_pkg::word_kind_e kind,
    input lane_codec_pkg::capability_s cap,
    input logic reason
  );
    lane_codec_pkg::symbol_s ident;
    ident = dsym(lane_codec_pkg::LANE_LAYER_IDENTIFIER);
    case (kind)
      lane_codec_pkg::WORD_ONE: begin
        build_word = {dsym(lane_codec_pkg::D6_2),
          dsym(lane_codec_pkg::D6_2), ident,
          ksym(lane_codec_pkg::K28_5)};
      end
      lane_codec_pkg::WORD_TWO: begin
        build_word = {dsym(lane_codec_pkg::D6_5),
          dsym(lane_codec_pkg::D6_5), ident,
          ksym(lane_codec_pkg::K28_5)};
      end
      lane_codec_pkg::WORD_THREE: begin
        build_word = {dsym(cap), dsym(lane_codec_pkg::D24_1),
          ident, ksym(lane_codec_pkg::K28_5)};
      end
      lane_codec_pkg::WORD_STANDBY: begin
        build_word = {dsym(lane_codec_pkg::D30_3),
          dsym(lane_codec_pkg::D30_3), ident,
          ksym(lane_codec_pkg::K28_7)};
      end
      lane_codec_pkg::WORD_LOSS: begin
        build_word = {dsym({7'h00, reason}),
          dsym(lane_codec_pkg::D4_3), ident,
          ksym(lane_codec_pkg::K28_7)};
      end
      default: begin
        build_word = '0;
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Transmit arbitration
  // ----------------------------------------------------------------
  lane_codec_pkg::word_t tx_word;
  lane_codec_pkg::word_kind_e tx_kind;
  lane_codec_pkg::word_kind_e next_kind;
  lane_codec_pkg::capability_s tx_cap;
  logic [1:0] tx_index;
  logic [4:0] standby_sent;
  logic can_load;
  logic loss_needed;
  logic loss_reason;
  logic req_ok;

  assign can_load = !tx_valid || (tx_ready && (tx_index == 2'h3));
  assign tx_symbol = tx_word[0];

  // Flags describe this end's own setup
  assign tx_cap = {5'h00, control.scramble, control.explicit_start,
                   control.remote_flush};

  // No signal outranks errors: without signal errors mean nothing
  assign loss_needed = no_signal || error_persist;
  assign loss_reason = !no_signal && error_persist;
  assign req_ok = word_req && (word_kind != lane_codec_pkg::WORD_NONE)
    && (word_kind != lane_codec_pkg::WORD_LOSS);

  // Standby first, then loss notice, then the lane logic's request
  always_comb begin
    next_kind = lane_codec_pkg::WORD_NONE;
    word_ack = 1'b0;
    if (standby_req) begin
      if (standby_sent < lane_codec_pkg::STANDBY_SEND_COUNT) begin
        next_kind = lane_codec_pkg::WORD_STANDBY;
      end
    end else if (loss_needed && !loss_suppressed) begin
      next_kind = lane_codec_pkg::WORD_LOSS;
    end else if (req_ok) begin
      next_kind = word_kind;
      word_ack = can_load;
    end
  end

  // Shift register: symbol 0 leaves first, one per accepted beat
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_word <= '0;
      tx_valid <= 1'b0;
      tx_index <= 2'h0;
      tx_kind <= lane_codec_pkg::WORD_NONE;
    end else if (can_load) begin
      tx_word <= build_word(next_kind, tx_cap, loss_reason);
      tx_valid <= (next_kind != lane_codec_pkg::WORD_NONE);
      tx_index <= 2'h0;
      tx_kind <= next_kind;
    end else if (tx_ready) begin
      tx_word <= {9'h000, tx_word[3:1]};
      tx_index <= tx_index + 2'h1;
    end
  end

  // Standby words sent since the request rose
  always_ff @(posedge clock) begin
    if (reset || !standby_req) begin
      standby_sent <= 5'h00;
    end else if (can_load &&
                 (next_kind == lane_codec_pkg::WORD_STANDBY)) begin
      standby_sent <= standby_sent + 5'h01;
    end
  end

  // Driver goes off only once the warning words have all left
  always_ff @(posedge clock) begin
    if (reset) begin
      driver_enable <= 1'b1;
    end else begin
      driver_enable <= !(standby_req && can_load &&
        (standby_sent == lane_codec_pkg::STANDBY_SEND_COUNT));
    end
  end

  // ----------------------------------------------------------------
  // Receive error persistence
  // ----------------------------------------------------------------
  logic [9:0] err_window;
  logic [3:0] err_count;

  // Fixed windows: a burst split over two windows may go unseen
  always_ff @(posedge clock) begin
    if (reset) begin
      err_window <= 10'h000;
      err_count <= 4'h0;
      error_persist <= 1'b0;
    end else if (err_window == lane_codec_pkg::ERR_WINDOW_LAST) begin
      err_window <= 10'h000;
      err_count <= 4'h0;
      error_persist <= (err_count >= lane_codec_pkg::ERR_LIMIT);
    end else begin
      err_window <= err_window + 10'h001;
      if (rx_error && (err_count != 4'hF)) begin
        err_count <= err_count + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive assembly and recognition
  // ----------------------------------------------------------------
  lane_codec_pkg::symbol_s [2:0] rx_buf;
  lane_codec_pkg::symbol_s rx_fixed;
  lane_codec_pkg::word_t rx_word;
  lane_codec_pkg::word_kind_e found_kind;
  logic [1:0] rx_count;
  logic rx_active;
  logic rx_comma;
  logic rx_finish;
  logic found_inverted;

  // K symbols stay as sent: the init comma reads the same inverted
  always_comb begin
    rx_fixed = rx_symbol;
    if (polarity_swapped && !rx_symbol.k) begin
      rx_fixed.data = ~rx_symbol.data;
    end
  end

  assign rx_comma = rx_symbol.k && ((rx_symbol.data ==
    lane_codec_pkg::K28_5) || (rx_symbol.data == lane_codec_pkg::K28_7));
  assign rx_finish = rx_valid && !rx_comma && rx_active &&
                     (rx_count == 2'h3);
  assign rx_word = {rx_fixed, rx_buf[2], rx_buf[1], rx_buf[0]};

  // A comma restarts the word, so a torn word is simply dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_buf <= '0;
      rx_count <= 2'h0;
      rx_active <= 1'b0;
    end else if (rx_valid) begin
      if (rx_comma) begin
        rx_buf[0] <= rx_fixed;
        rx_count <= 2'h1;
        rx_active <= 1'b1;
      end else if (rx_finish) begin
        rx_count <= 2'h0;
        rx_active <= 1'b0;
      end else if (rx_active) begin
        rx_buf[rx_count] <= rx_fixed;
        rx_count <= rx_count + 2'h1;
      end
    end
  end

  // Recognise a complete word; other lane words give WORD_NONE
  always_comb begin
    logic init_comma;
    logic normal_id;
    logic inv_id;
    logic pair;
    init_comma = rx_word[0].data == lane_codec_pkg::K28_5;
    normal_id = !rx_word[1].k &&
      (rx_word[1].data == lane_codec_pkg::LANE_LAYER_IDENTIFIER);
    inv_id = !rx_word[1].k && !polarity_swapped && (rx_word[1].data ==
      lane_codec_pkg::INVERTED_LANE_LAYER_IDENTIFIER);
    pair = !rx_word[2].k && !rx_word[3].k &&
      (rx_word[2].data == rx_word[3].data);
    found_kind = lane_codec_pkg::WORD_NONE;
    found_inverted = 1'b0;
    if (init_comma && normal_id && pair &&
        (rx_word[2].data == lane_codec_pkg::D6_2)) begin
      found_kind = lane_codec_pkg::WORD_ONE;
    end else if (init_comma && normal_id && pair &&
                 (rx_word[2].data == lane_codec_pkg::D6_5)) begin
      found_kind = lane_codec_pkg::WORD_TWO;
    end else if (init_comma && normal_id && !rx_word[3].k &&
                 (rx_word[2].data == lane_codec_pkg::D24_1)) begin
      found_kind = lane_codec_pkg::WORD_THREE;
    end else if (init_comma && inv_id && pair &&
                 (rx_word[2].data == lane_codec_pkg::D25_5)) begin
      found_kind = lane_codec_pkg::WORD_ONE;
      found_inverted = 1'b1;
    end else if (init_comma && inv_id && pair &&
                 (rx_word[2].data == lane_codec_pkg::D25_2)) begin
      found_kind = lane_codec_pkg::WORD_TWO;
      found_inverted = 1'b1;
    end else if (!init_comma && normal_id && pair &&
                 (rx_word[2].data == lane_codec_pkg::D30_3)) begin
      found_kind = lane_codec_pkg::WORD_STANDBY;
    end else if (!init_comma && normal_id && !rx_word[3].k &&
                 (rx_word[2].data == lane_codec_pkg::D4_3)) begin
      found_kind = lane_codec_pkg::WORD_LOSS;
    end
  end

  // Word report and flag capture; reserved bits are dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_word_valid <= 1'b0;
      rx_word_kind <= lane_codec_pkg::WORD_NONE;
      rx_capability <= 3'h0;
      rx_loss_reason <= 1'b0;
      rx_flush <= 1'b0;
    end else begin
      rx_word_valid <= rx_finish &&
        (found_kind != lane_codec_pkg::WORD_NONE);
      rx_flush <= rx_finish && rx_word[3].data[0] &&
        (found_kind == lane_codec_pkg::WORD_THREE);
      if (rx_finish) begin
        rx_word_kind <= found_kind;
      end
      if (rx_finish && (found_kind == lane_codec_pkg::WORD_THREE)) begin
        rx_capability <= rx_word[3].data[2:0];
      end
      if (rx_finish && (found_kind == lane_codec_pkg::WORD_LOSS)) begin
        rx_loss_reason <= rx_word[3].data[0];
      end
    end
  end

  // Swap detection wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      polarity_swapped <= 1'b0;
    end else if (rx_finish && found_inverted) begin
      polarity_swapped <= 1'b1;
    end else if (polarity_clear) begin
      polarity_swapped <= 1'b0;
    end
  end

  // Consecutive standby words heard; any other word resets the run
  always_ff @(posedge clock) begin
    if (reset) begin
      standby_heard <= 4'h0;
    end else if (rx_finish) begin
      if (found_kind != lane_codec_pkg::WORD_STANDBY) begin
        standby_heard <= 4'h0;
      end else if (standby_heard != lane_codec_pkg::STANDBY_HEARD_LIMIT)
      begin
        standby_heard <= standby_heard + 4'h1;
      end
    end
  end

  assign loss_suppressed =
    (standby_heard == lane_codec_pkg::STANDBY_HEARD_LIMIT);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_comma_first;
    @(posedge clock) disable iff (reset)
    tx_valid && (tx_index == 2'h0) |-> tx_symbol.k;
  endproperty
  a_comma_first: assert property (p_comma_first)
    else $error("word does not start with a comma");

  property p_ident_second;
    @(posedge clock) disable iff (reset)
    tx_valid && (tx_index == 2'h1) |->
      !tx_symbol.k && (tx_symbol.data == 8'hCE);
  endproperty
  a_ident_second: assert property (p_ident_second)
    else $error("second symbol is not the identifier");

  property p_repeat_fourth;
    @(posedge clock) disable iff (reset)
    tx_valid && (tx_index == 2'h3) && $past(tx_index) == 2'h2 &&
      (tx_kind == lane_codec_pkg::WORD_ONE) |->
      tx_symbol == $past(tx_symbol) && tx_symbol.data == 8'h46;
  endproperty
  a_repeat_fourth: assert property (p_repeat_fourth)
    else $error("fourth symbol does not repeat the third");

  property p_no_inverted_id;
    @(posedge clock) disable iff (reset)
    tx_valid |-> (tx_symbol.data != 8'h31) || tx_symbol.k;
  endproperty
  a_no_inverted_id: assert property (p_no_inverted_id)
    else $error("inverted identifier transmitted");

  property p_cap_reserved;
    @(posedge clock) disable iff (reset)
    tx_valid && (tx_index == 2'h3) &&
      (tx_kind == lane_codec_pkg::WORD_THREE) |->
      tx_symbol.data[7:3] == 5'h00;
  endproperty
  a_cap_reserved: assert property (p_cap_reserved)
    else $error("capability reserved bits not zero");

  property p_reason_reserved;
    @(posedge clock) disable iff (reset)
    tx_valid && (tx_index == 2'h3) &&
      (tx_kind == lane_codec_pkg::WORD_LOSS) |->
      tx_symbol.data[7:1] == 7'h00;
  endproperty
  a_reason_reserved: assert property (p_reason_reserved)
    else $error("loss reason reserved bits not zero");

  property p_flush;
    @(posedge clock) disable iff (reset)
    rx_finish && (found_kind == lane_codec_pkg::WORD_THREE) |->
      ##1 (rx_flush == $past(rx_word[3].data[0]));
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush does not follow the flag");

  property p_driver_off;
    @(posedge clock) disable iff (reset)
    $fell(driver_enable) |-> (standby_sent == 5'h10) && !tx_valid;
  endproperty
  a_driver_off: assert property (p_driver_off)
    else $error("driver off before standby words sent");

  property p_loss_sent;
    @(posedge clock) disable iff (reset)
    loss_needed && !loss_suppressed && !standby_req && !tx_valid |->
      ##1 tx_valid && (tx_kind == lane_codec_pkg::WORD_LOSS);
  endproperty
  a_loss_sent: assert property (p_loss_sent)
    else $error("loss word not started");

  property p_suppress;
    @(posedge clock) disable iff (reset)
    loss_suppressed && can_load |=>
      tx_kind != lane_codec_pkg::WORD_LOSS;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("loss word sent after standby run");

  property p_swap;
    @(posedge clock) disable iff (reset)
    rx_finish && found_inverted |=> polarity_swapped && rx_word_valid;
  endproperty
  a_swap: assert property (p_swap)
    else $error("inverted word did not set swap");

  c_standby_off: cover property (@(posedge clock) disable iff (reset)
    $fell(driver_enable));
  c_swap: cover property (@(posedge clock) disable iff (reset)
    $rose(polarity_swapped));
  c_flush: cover property (@(posedge clock) disable iff (reset)
    rx_flush);
  c_suppress: cover property (@(posedge clock) disable iff (reset)
    loss_suppressed && loss_needed);

endmodule // lane_control_word_codec

`default_nettype wire

// ===== lane_codec_pkg.sv
/*
  Shared constants and carriers for the lane control word codec:
  symbol codes, word kinds, register layout and timing counts.
  Assumes decoded 8b/10b symbols (k flag plus eight data bits).
*/
`default_nettype none

package lane_codec_pkg;

  // ----------------------------------------------------------------
  // Symbols and words
  // ----------------------------------------------------------------
  // One decoded symbol; data is {y[2:0], x[4:0]} for Dx.y / Kx.y
  typedef struct packed {
    logic k;
    logic [7:0] data;
  } symbol_s;

  // Four symbols, index 0 is sent first
  typedef symbol_s [3:0] word_t;

  typedef enum logic [2:0] {
    WORD_NONE,
    WORD_ONE,
    WORD_TWO,
    WORD_THREE,
    WORD_STANDBY,
    WORD_LOSS
  } word_kind_e;

  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [7:0] K28_7 = 8'hFC;
  localparam logic [7:0] LANE_LAYER_IDENTIFIER = 8'hCE;
  localparam logic [7:0] INVERTED_LANE_LAYER_IDENTIFIER = 8'h31;
  localparam logic [7:0] D6_2 = 8'h46;
  localparam logic [7:0] D25_5 = 8'hB9;
  localparam logic [7:0] D6_5 = 8'hA6;
  localparam logic [7:0] D25_2 = 8'h59;
  localparam logic [7:0] D24_1 = 8'h38;
  localparam logic [7:0] D30_3 = 8'h7E;
  localparam logic [7:0] D4_3 = 8'h64;

  // Capability symbol layout
  typedef struct packed {
    logic [4:0] reserved;
    logic scrambled;
    logic explicit_start;
    logic remote_flush;
  } capability_s;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CONTROL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

  typedef struct packed {
    logic [27:0] reserved;
    logic polarity_clear;
    logic remote_flush;
    logic scramble;
    logic explicit_start;
  } control_s;

  typedef struct packed {
    logic [19:0] reserved;
    logic [3:0] standby_heard;
    logic far_loss_reason;
    logic [2:0] far_capability;
    logic reserved_low;
    logic error_persist;
    logic loss_suppressed;
    logic polarity_swapped;
  } status_s;

  localparam control_s CONTROL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Counts and times
  // ----------------------------------------------------------------
  localparam logic [3:0] STANDBY_HEARD_LIMIT = 4'h8;
  localparam logic [4:0] STANDBY_SEND_COUNT = 5'h10;
  localparam logic [3:0] ERR_LIMIT = 4'h8;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int ERR_WINDOW_NS = 10000;
  localparam int ERR_WINDOW_CYCLES = ERR_WINDOW_NS / CLOCK_PERIOD_NS;
  localparam logic [9:0] ERR_WINDOW_LAST = 10'(ERR_WINDOW_CYCLES - 1);

endpackage

`default_nettype wire

// ===== far_lane_model.sv
/* Far end of the lane: takes transmit symbols, stalling on request.
   Assumes symbols from the codec change only after a rising edge. */
`timescale 1ns/100ps
`default_nettype none
module far_lane_model (
  input wire logic clock,
  input wire logic slow,
  input wire lane_codec_pkg::symbol_s tx_symbol,
  input wire logic tx_valid,
  output logic tx_ready,
  output lane_codec_pkg::word_t got,
  output logic [2:0] cnt
);
  // Toggling ready when slow makes every symbol wait a cycle
  always_ff @(posedge clock) begin
    tx_ready <= !slow || !tx_ready;
  end
  // A comma realigns, so the first symbol ends in got[0]
  always_ff @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got <= {tx_symbol, got[3:1]};
      cnt <= tx_symbol.k ? 3'h1 : cnt + 3'h1;
    end
  end
endmodule // far_lane_model
`default_nettype wire

// ===== testbench.sv
/* Bench for the lane codec: a table of sent words, then receive,
   register, loss and standby cases. Assumes the far lane model. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic word_req = 1'b0, standby_req = 1'b0, no_signal = 1'b0;
  logic rx_valid = 1'b0, slow = 1'b0, rx_error = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  lane_codec_pkg::word_kind_e word_kind = lane_codec_pkg::WORD_NONE;
  lane_codec_pkg::symbol_s rx_symbol = 9'h000;
  wire lane_codec_pkg::symbol_s tx_symbol;
  wire lane_codec_pkg::word_kind_e rx_word_kind;
  wire lane_codec_pkg::word_t got;
  wire logic [2:0] cnt, rx_capability;
  wire logic [31:0] hrdata;
  wire logic hreadyout, word_ack, tx_valid, tx_ready, driver_enable;
  wire logic rx_word_valid, rx_flush, polarity_swapped, hresp;
  wire logic rx_loss_reason;
  lane_codec_pkg::word_t w;
  int mismatches = 0, total_checks = 0;
  typedef struct {
    lane_codec_pkg::word_kind_e kind;
    logic slow;
    logic [8:0] a, c, d;
  } row_s;
  // Third word carries control 0x7: flags set, reserved bits zero
  row_s rows [4] = '{
    '{lane_codec_pkg::WORD_ONE, 1'b0, 9'h1BC, 9'h046, 9'h046},
    '{lane_codec_pkg::WORD_TWO, 1'b0, 9'h1BC, 9'h0A6, 9'h0A6},
    '{lane_codec_pkg::WORD_THREE, 1'b1, 9'h1BC, 9'h038, 9'h007},
    '{lane_codec_pkg::WORD_STANDBY, 1'b0, 9'h1FC, 9'h07E, 9'h07E}};
  lane_control_word_codec uut (.clock(clock), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .word_req(word_req), .word_kind(word_kind), .word_ack(word_ack),
    .standby_req(standby_req), .no_signal(no_signal), .rx_error(rx_error),
    .tx_symbol(tx_symbol), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .driver_enable(driver_enable), .rx_symbol(rx_symbol),
    .rx_valid(rx_valid), .rx_word_kind(rx_word_kind),
    .rx_word_valid(rx_word_valid), .rx_capability(rx_capability),
    .rx_loss_reason(rx_loss_reason), .rx_flush(rx_flush),
    .polarity_swapped(polarity_swapped));
  far_lane_model far (.clock(clock), .slow(slow), .tx_symbol(tx_symbol),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .got(got), .cnt(cnt));
  always #5 clock = ~clock;
  task automatic cmp(input logic [35:0] g, e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic send(input lane_codec_pkg::word_kind_e k);
    word_req <= 1'b1;
    word_kind <= k;
    do @(negedge clock); while (word_ack !== 1'b1);
    @(posedge clock);
    word_req <= 1'b0;
  endtask
  // Waits for the next whole word at the far end
  task automatic grab();
    do @(negedge clock); while (cnt === 3'h4);
    do @(negedge clock); while (cnt !== 3'h4);
    w = got;
  endtask
  // Symbols change just after a rising edge; result read at the negedge
  task automatic rx_word(input lane_codec_pkg::word_t v);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      rx_symbol <= v[i];
      rx_valid <= 1'b1;
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    @(negedge clock);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly eleven hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    cmp(36'({tx_valid, driver_enable, hresp}), 36'h2);
    ahb(1'b1, 32'h0, 32'hF);
    ahb(1'b0, 32'h0, 32'h0);
    cmp(36'(r), 36'h7);
    ahb(1'b0, 32'h8, 32'h0);
    cmp(36'(r), 36'h0);
    foreach (rows[i]) begin
      @(posedge clock);
      slow <= rows[i].slow;
      send(rows[i].kind);
      grab();
      cmp(w, {rows[i].d, rows[i].c, 9'h0CE,
        rows[i].a});
    end
    slow <= 1'b0;
    rx_word({9'h0F9, 9'h038, 9'h0CE, 9'h1BC});
    cmp(36'({rx_word_valid, rx_flush, rx_capability, rx_word_kind}),
        36'({2'h3, 3'h1, lane_codec_pkg::WORD_THREE}));
    rx_word({9'h0FF, 9'h064, 9'h0CE, 9'h1FC});
    cmp(36'({rx_word_valid, rx_loss_reason, rx_word_kind}),
        36'({2'h3, lane_codec_pkg::WORD_LOSS}));
    for (int i = 0; i < 8; i++) rx_word({9'h07E, 9'h07E, 9'h0CE, 9'h1FC});
    ahb(1'b0, 32'h4, 32'h0);
    cmp(36'(r[11:0]), 36'h892);
    // Far end is going quiet: no loss word even without signal
    @(posedge clock);
    no_signal <= 1'b1;
    repeat (8) @(negedge clock);
    cmp(36'(tx_valid), 36'h0);
    @(posedge clock);
    no_signal <= 1'b0;
    rx_word({9'h0B9, 9'h0B9, 9'h031, 9'h1BC});
    cmp(36'({rx_word_valid, polarity_swapped, rx_word_kind}),
        36'({2'h3, lane_codec_pkg::WORD_ONE}));
    rx_word({9'h059, 9'h059, 9'h031, 9'h1BC});
    cmp(36'({rx_word_valid, rx_word_kind}),
        36'({1'b1, lane_codec_pkg::WORD_TWO}));
    // Software clear, then the inverted second word sets the swap again
    ahb(1'b1, 32'h0, 32'hF);
    @(negedge clock);
    cmp(36'(polarity_swapped), 36'h0);
    rx_word({9'h059, 9'h059, 9'h031, 9'h1BC});
    cmp(36'({rx_word_valid, polarity_swapped, rx_word_kind}),
        36'({2'h3, lane_codec_pkg::WORD_TWO}));
    @(posedge clock);
    no_signal <= 1'b1;
    grab();
    cmp(w, {9'h000, 9'h064, 9'h0CE, 9'h1FC});
    @(posedge clock);
    no_signal <= 1'b0;
    // Twenty error pulses: at least eight land in one window
    repeat (20) begin
      @(posedge clock);
      rx_error <= 1'b1;
      @(posedge clock);
      rx_error <= 1'b0;
    end
    grab();
    cmp(w, {9'h001, 9'h064, 9'h0CE, 9'h1FC});
    @(posedge clock);
    standby_req <= 1'b1;
    grab();
    // Driver stays on until the last of sixteen standby words
    for (int i = 0; i < 16; i++) begin
      grab();
      cmp(w, {9'h07E, 9'h07E, 9'h0CE, 9'h1FC});
      cmp(36'(driver_enable), 36'(i < 15));
    end
    // Reset in mid-run clears flags, counts and the standby state
    @(posedge clock);
    reset <= 1'b1;
    standby_req <= 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    cmp(36'({tx_valid, driver_enable, polarity_swapped}), 36'h2);
    ahb(1'b0, 32'h4, 32'h0);
    cmp(36'(r), 36'h0);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
